// [rtl/hbs_sequencer.sv]
// Half-bridge gate sequencer with adaptive dead time and undervoltage gating.
// What this block does
// - Boost undervoltage stops switching at the next low-side turn-on.
// - Switching resumes once boost rises above the separate start level.
// - Successive oscillator cycles go alternately to high and low side.
// - Oscillator runs at twice bridge frequency; two cycles per bridge period.
// - Conducting switch turns off at the end of its oscillator cycle.
// - Opposite switch turns on as soon as the bridge slope ends.
// - A fixed minimum dead time always separates the two gates.
// - Slope still running at end of charge phase forces next switch on.
// - In capacitive mode the opposite switch waits until the slope starts.
// - Oscillator runs slowed while waiting for the slope to begin.
// - Ramp reaching upper threshold without slope forces the waiting switch on.
// - Switching starts only with protections clear and enable input active.
// - Charge current starts reduced, goes normal once slope start is seen.
`timescale 1ns/1ps
`include "hbs_regs.svh"

module hbs_sequencer (
  input  wire logic ref_clk_in,
  input  wire logic sys_rst_in,
  input  wire logic clk_en_in,
  input  wire logic slope_start_in,
  input  wire logic slope_end_in,
  input  wire logic ramp_upper_threshold_in,
  input  wire logic ramp_lower_threshold_in,
  input  wire logic boost_sense_uv_in,
  input  wire logic boost_sense_start_in,
  input  wire logic protection_fault_in,
  input  wire logic softstart_enable_input_in,
  output logic      high_side_gate_out,
  output logic      low_side_gate_out,
  output logic      osc_reduced_charge_out,
  output logic      running_out
);

  localparam logic [`HBS_DEAD_CNT_W-1:0] DEAD_MIN = `HBS_DEAD_CNT_W'(`HBS_DEAD_MIN_CYC);
  hbs_pkg::hbs_flags_t raw;
  hbs_pkg::hbs_flags_t s1_q;
  hbs_pkg::hbs_flags_t s2_q;
  hbs_pkg::hbs_flags_t s3_q;
  hbs_pkg::hbs_flags_t flt_q;
  hbs_pkg::hbs_flags_t prev_q;
  hbs_pkg::hbs_state_t state_q;
  logic                         side_q;
  logic                         uv_stop_q;
  logic [`HBS_DEAD_CNT_W-1:0]   dead_cnt_q;
  logic                         run_ok;
  logic                         dead_done;
  logic                         lower_rise;
  logic                         upper_rise;
  logic                         start_rise;
  logic                         turn_on_req;

  assign raw = '{enable: softstart_enable_input_in, fault: protection_fault_in,
                 boost_start: boost_sense_start_in, boost_uv: boost_sense_uv_in,
                 ramp_lower: ramp_lower_threshold_in, ramp_upper: ramp_upper_threshold_in,
                 slope_end: slope_end_in, slope_start: slope_start_in};

  // Three stages per flag; the filtered value only moves when stages two and three agree.
  genvar gi;
  generate
    for (gi = 0; gi < `HBS_SYNC_W; gi++)
    begin : g_sync
      always_ff @(posedge ref_clk_in or posedge sys_rst_in)
      begin
        if (sys_rst_in)
        begin
          s1_q[gi]  <= 1'b0;
          s2_q[gi]  <= 1'b0;
          s3_q[gi]  <= 1'b0;
          flt_q[gi] <= 1'b0;
        end
        else if (clk_en_in)
        begin
          s1_q[gi] <= raw[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          if (s2_q[gi] == s3_q[gi])
            flt_q[gi] <= s3_q[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      prev_q <= `HBS_SYNC_RST;
    else if (clk_en_in)
      prev_q <= flt_q;
  end

  assign lower_rise = flt_q.ramp_lower & ~prev_q.ramp_lower;
  assign upper_rise = flt_q.ramp_upper & ~prev_q.ramp_upper;
  assign start_rise = flt_q.slope_start & ~prev_q.slope_start;
  assign run_ok     = flt_q.enable & ~flt_q.fault;
  assign dead_done  = (dead_cnt_q >= DEAD_MIN);

  // The slope end is level-sensed so a slope that ended during the dead time still counts.
  assign turn_on_req = ((state_q == hbs_pkg::ST_SLOPE) & (flt_q.slope_end | upper_rise))
                     | ((state_q == hbs_pkg::ST_WAIT) & upper_rise);

  // Undervoltage latch: the start flag clears it, giving hysteresis; a new dip wins.
  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      uv_stop_q <= 1'b0;
    else if (clk_en_in)
    begin
      if (flt_q.boost_uv)
        uv_stop_q <= 1'b1;
      else if (flt_q.boost_start)
        uv_stop_q <= 1'b0;
    end
  end

  // Counts cycles with both gates off, saturating.
  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      dead_cnt_q <= '0;
    else if (clk_en_in)
    begin
      if (high_side_gate_out | low_side_gate_out)
        dead_cnt_q <= '0;
      else if (!dead_done)
        dead_cnt_q <= dead_cnt_q + `HBS_DEAD_CNT_W'(1);
    end
  end

  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      state_q                <= hbs_pkg::ST_IDLE;
      side_q                 <= `HBS_SIDE_LOW;
      high_side_gate_out     <= 1'b0;
      low_side_gate_out      <= 1'b0;
      osc_reduced_charge_out <= 1'b0;
      running_out            <= 1'b0;
    end
    else if (clk_en_in)
    begin
      if (!run_ok)
      begin
        state_q                <= hbs_pkg::ST_IDLE;
        side_q                 <= `HBS_SIDE_LOW;
        high_side_gate_out     <= 1'b0;
        low_side_gate_out      <= 1'b0;
        osc_reduced_charge_out <= 1'b0;
        running_out            <= 1'b0;
      end
      else
      begin
        unique case (state_q)
          hbs_pkg::ST_IDLE:
          begin
            // Starting on the low side charges the bootstrap supply first.
            if (!uv_stop_q && dead_done)
            begin
              state_q           <= hbs_pkg::ST_CONDUCT;
              side_q            <= `HBS_SIDE_LOW;
              low_side_gate_out <= 1'b1;
              running_out       <= 1'b1;
            end
          end
          hbs_pkg::ST_CONDUCT:
          begin
            if (lower_rise)
            begin
              high_side_gate_out     <= 1'b0;
              low_side_gate_out      <= 1'b0;
              side_q                 <= ~side_q;
              osc_reduced_charge_out <= 1'b1;
              state_q                <= flt_q.slope_start ? hbs_pkg::ST_SLOPE : hbs_pkg::ST_WAIT;
            end
          end
          hbs_pkg::ST_WAIT:
          begin
            if (start_rise || flt_q.slope_start)
            begin
              state_q                <= hbs_pkg::ST_SLOPE;
              osc_reduced_charge_out <= 1'b0;
            end
            else if (turn_on_req && dead_done)
            begin
              osc_reduced_charge_out <= 1'b0;
              if (side_q == `HBS_SIDE_LOW && uv_stop_q)
              begin
                state_q     <= hbs_pkg::ST_IDLE;
                side_q      <= `HBS_SIDE_LOW;
                running_out <= 1'b0;
              end
              else
              begin
                state_q            <= hbs_pkg::ST_CONDUCT;
                high_side_gate_out <= side_q;
                low_side_gate_out  <= ~side_q;
              end
            end
          end
          hbs_pkg::ST_SLOPE:
          begin
            osc_reduced_charge_out <= 1'b0;
            if (turn_on_req && dead_done)
            begin
              if (side_q == `HBS_SIDE_LOW && uv_stop_q)
              begin
                state_q     <= hbs_pkg::ST_IDLE;
                running_out <= 1'b0;
              end
              else
              begin
                state_q            <= hbs_pkg::ST_CONDUCT;
                high_side_gate_out <= side_q;
                low_side_gate_out  <= ~side_q;
              end
            end
          end
          default:
          begin
            state_q            <= hbs_pkg::ST_IDLE;
            high_side_gate_out <= 1'b0;
            low_side_gate_out  <= 1'b0;
          end
        endcase
      end
    end
  end

  logic chk_last_low_q;
  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      chk_last_low_q <= 1'b0;
    else if (low_side_gate_out)
      chk_last_low_q <= 1'b1;
    else if (high_side_gate_out || state_q == hbs_pkg::ST_IDLE)
      chk_last_low_q <= 1'b0;
  end

  sequence s_cycle_end;
    clk_en_in && run_ok && state_q == hbs_pkg::ST_CONDUCT && lower_rise;
  endsequence

  sequence s_gates_off;
    !high_side_gate_out && !low_side_gate_out;
  endsequence

  property p_no_overlap;
    @(posedge ref_clk_in) disable iff (sys_rst_in) !(high_side_gate_out && low_side_gate_out);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("Both gates high.");

  property p_min_dead;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      ($rose(high_side_gate_out) || $rose(low_side_gate_out)) |-> $past(dead_cnt_q) >= DEAD_MIN;
  endproperty
  a_min_dead: assert property (p_min_dead) else $error("Gate on before minimum dead time.");

  property p_alternate;
    @(posedge ref_clk_in) disable iff (sys_rst_in) $rose(high_side_gate_out) |-> $past(chk_last_low_q);
  endproperty
  a_alternate: assert property (p_alternate) else $error("High side on without low side before.");

  property p_off_at_end;
    @(posedge ref_clk_in) disable iff (sys_rst_in) s_cycle_end |=> s_gates_off ##0 osc_reduced_charge_out;
  endproperty
  a_off_at_end: assert property (p_off_at_end) else $error("Gate not off at cycle end.");

  property p_force_on;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      clk_en_in && run_ok && state_q == hbs_pkg::ST_SLOPE && upper_rise && dead_done && !uv_stop_q
      |=> (high_side_gate_out || low_side_gate_out);
  endproperty
  a_force_on: assert property (p_force_on) else $error("Switch not forced on at charge end.");

  property p_wait_slope;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      state_q == hbs_pkg::ST_WAIT && !upper_rise |=> s_gates_off;
  endproperty
  a_wait_slope: assert property (p_wait_slope) else $error("Gate on before slope start.");

  property p_uv_stop;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      clk_en_in && run_ok && uv_stop_q && side_q == `HBS_SIDE_LOW && turn_on_req && dead_done
      && !(state_q == hbs_pkg::ST_WAIT && flt_q.slope_start) |=> s_gates_off ##0 state_q == hbs_pkg::ST_IDLE;
  endproperty
  a_uv_stop: assert property (p_uv_stop) else $error("Low side turned on under undervoltage.");

  property p_disable;
    @(posedge ref_clk_in) disable iff (sys_rst_in)
      clk_en_in && !run_ok |=> s_gates_off ##0 state_q == hbs_pkg::ST_IDLE ##0 side_q == `HBS_SIDE_LOW ##0 !running_out;
  endproperty
  a_disable: assert property (p_disable) else $error("Gates active while disabled.");
endmodule : hbs_sequencer

// [common/hbs_regs.svh]
// Timing counts and reset values for the half-bridge switch sequencer.
`ifndef HBS_REGS_SVH
`define HBS_REGS_SVH
`define HBS_CLK_MHZ          100
`define HBS_T_DEAD_MIN_NS    100
`define HBS_DEAD_MIN_CYC     ((`HBS_T_DEAD_MIN_NS * `HBS_CLK_MHZ + 999) / 1000)
`define HBS_DEAD_CNT_W       8
`define HBS_SYNC_W           8
`define HBS_SYNC_RST         8'h00
`define HBS_SIDE_LOW         1'b0
`define HBS_SIDE_HIGH        1'b1
`endif

// [common/hbs_pkg.sv]
// Types shared by the half-bridge switch sequencer.
package hbs_pkg;

  typedef struct packed {
    logic enable;
    logic fault;
    logic boost_start;
    logic boost_uv;
    logic ramp_lower;
    logic ramp_upper;
    logic slope_end;
    logic slope_start;
  } hbs_flags_t;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'h1,
    ST_CONDUCT = 4'h2,
    ST_WAIT    = 4'h4,
    ST_SLOPE   = 4'h8
  } hbs_state_t;

endpackage : hbs_pkg

// [verif/hbs_bridge_model.sv]
// Model of the half-bridge power switches and the bridge midpoint slope sensor.
`timescale 1ns/1ps
module hbs_bridge_model (
  input  wire logic       ref_clk_in,
  input  wire logic       high_side_gate_in,
  input  wire logic       low_side_gate_in,
  input  wire logic [7:0] start_dly_in,
  input  wire logic [7:0] end_dly_in,
  output logic            slope_start_out,
  output logic            slope_end_out
);
  int cnt = 0;
  // A start delay of 8'hff means the slope never comes, which is how capacitive mode looks from outside.
  always_ff @(posedge ref_clk_in)
  begin
    if (high_side_gate_in || low_side_gate_in)
    begin
      cnt             <= 0;
      slope_start_out <= 1'b0;
      slope_end_out   <= 1'b0;
    end
    else
    begin
      cnt             <= cnt + 1;
      slope_start_out <= (start_dly_in != 8'hff) && (cnt >= start_dly_in);
      slope_end_out   <= (start_dly_in != 8'hff) && (end_dly_in != 8'hff) && (cnt >= start_dly_in + end_dly_in);
    end
  end
endmodule : hbs_bridge_model

// [verif/tb.sv]
// Self-checking bench for the half-bridge switch sequencer.
`timescale 1ns/1ps
module tb;
  logic       ref_clk_in, sys_rst_in, ramp_up, ramp_lo, uv, bst, fault, en, ce;
  logic       hs, ls, red, run, s_start, s_end, side;
  logic [7:0] sdly, edly;
  logic [1:0] prev;
  logic [1:0] exp_q[$];
  int         num_errors, n_checks, dead;

  hbs_sequencer i_dut (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(ce),
    .slope_start_in(s_start), .slope_end_in(s_end), .ramp_upper_threshold_in(ramp_up),
    .ramp_lower_threshold_in(ramp_lo), .boost_sense_uv_in(uv), .boost_sense_start_in(bst),
    .protection_fault_in(fault), .softstart_enable_input_in(en), .high_side_gate_out(hs),
    .low_side_gate_out(ls), .osc_reduced_charge_out(red), .running_out(run));
  hbs_bridge_model i_bridge (.ref_clk_in(ref_clk_in), .high_side_gate_in(hs), .low_side_gate_in(ls),
    .start_dly_in(sdly), .end_dly_in(edly), .slope_start_out(s_start), .slope_end_out(s_end));

  task automatic chk(input string what, input logic [1:0] e, input logic [1:0] s);
    n_checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("BAD %s expected %b seen %b", what, e, s);
    end
  endtask : chk

  task automatic close_out();
    if (num_errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out

  // Threshold flags are held four cycles so the three-stage filter cannot drop them.
  task automatic pulse(input bit upper);
    @(posedge ref_clk_in);
    if (upper)
      ramp_up <= 1'b1;
    else
      ramp_lo <= 1'b1;
    repeat (4) @(posedge ref_clk_in);
    ramp_up <= 1'b0;
    ramp_lo <= 1'b0;
  endtask : pulse

  task automatic wait_gates(input logic [1:0] v);
    for (int i = 0; i < 200 && {hs, ls} !== v; i++)
      @(negedge ref_clk_in);
    chk("gates", v, {hs, ls});
  endtask : wait_gates

  // One half period: mode 0 normal slope, 1 slope never ends, 2 slope never starts.
  task automatic half(input int mode);
    sdly = (mode == 2) ? 8'hff : 8'($urandom_range(0, 6));
    edly = (mode == 1) ? 8'hff : 8'($urandom_range(0, 12));
    exp_q.push_back(2'h0);
    exp_q.push_back(side ? 2'h1 : 2'h2);
    pulse(1'b0);
    wait_gates(2'h0);
    if (mode != 0)
    begin
      repeat (30) @(negedge ref_clk_in);
      chk("held off", 2'h0, {hs, ls});
      chk("reduced charge", {1'b0, mode == 2}, {1'b0, red});
      pulse(1'b1);
    end
    side = !side;
    wait_gates(side ? 2'h2 : 2'h1);
  endtask : half

  always @(negedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      prev = 2'h0;
      dead = 0;
    end
    else
    begin
      if ({hs, ls} !== prev)
      begin
        if (exp_q.size() == 0)
          chk("unexpected gates", prev, {hs, ls});
        else
          chk("gate change", exp_q.pop_front(), {hs, ls});
        if (prev === 2'h0)
          chk("dead time", 2'h1, {1'b0, dead >= 10});
        prev = {hs, ls};
      end
      dead = ({hs, ls} === 2'h0) ? dead + 1 : 0;
    end
  end

  initial
  begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = !ref_clk_in;
  end

  initial
  begin
    #200000;
    num_errors++;
    close_out();
  end

  initial
  begin
    {ramp_up, ramp_lo, uv, bst, fault, en, side} = '0;
    ce = 1'b1;
    sdly = 8'h2;
    edly = 8'h4;
    sys_rst_in = 1'b1;
    void'($urandom(32'h2510));
    repeat (10) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    @(negedge ref_clk_in);
    chk("reset gates", 2'h0, {hs, ls});
    chk("reset status", 2'h0, {red, run});
    repeat (5) @(posedge ref_clk_in);
    exp_q.push_back(2'h1);
    en <= 1'b1;
    wait_gates(2'h1);
    chk("running", 2'h1, {1'b0, run});
    // Single-cycle glitches on the level flags must never pass the agreement filter.
    repeat (8)
    begin
      @(posedge ref_clk_in);
      fault <= 1'($urandom);
      en    <= 1'($urandom);
      uv    <= 1'($urandom);
      @(posedge ref_clk_in);
      {fault, en, uv} <= 3'b010;
      repeat (2) @(posedge ref_clk_in);
    end
    chk("glitches", 2'h3, {run, ls});
    // A cycle end that arrives while the clock enable is low is never seen.
    @(posedge ref_clk_in);
    ce <= 1'b0;
    pulse(1'b0);
    repeat ($urandom_range(2, 20)) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    chk("frozen", 2'h3, {run, ls});
    @(posedge ref_clk_in);
    ce <= 1'b1;
    repeat (4) half(0);
    half(1);
    half(2);
    repeat (6) half($urandom_range(0, 2));
    if (side)
      half(0);
    @(posedge ref_clk_in);
    uv <= 1'b1;
    half(0);
    exp_q.push_back(2'h0);
    pulse(1'b0);
    wait_gates(2'h0);
    repeat (30) @(negedge ref_clk_in);
    chk("uv stopped", 2'h0, {ls, run});
    exp_q.push_back(2'h1);
    @(posedge ref_clk_in);
    uv <= 1'b0;
    bst <= 1'b1;
    side = 1'b0;
    wait_gates(2'h1);
    half(0);
    exp_q.push_back(2'h0);
    @(posedge ref_clk_in);
    fault <= 1'b1;
    wait_gates(2'h0);
    repeat (10) @(negedge ref_clk_in);
    chk("fault stopped", 2'h0, {hs, run});
    exp_q.push_back(2'h1);
    @(posedge ref_clk_in);
    fault <= 1'b0;
    side = 1'b0;
    wait_gates(2'h1);
    @(posedge ref_clk_in);
    sys_rst_in <= 1'b1;
    repeat (3) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    @(negedge ref_clk_in);
    chk("mid reset", 2'h0, {hs, run});
    chk("mid reset gates", 2'h0, {ls, red});
    exp_q.push_back(2'h1);
    wait_gates(2'h1);
    exp_q.push_back(2'h0);
    @(posedge ref_clk_in);
    en <= 1'b0;
    wait_gates(2'h0);
    repeat (10) @(negedge ref_clk_in);
    chk("queue drained", 2'h0, 2'(exp_q.size()));
    close_out();
  end
endmodule : tb
